//--- pwg_params.svh
// constants for the peripheral write guard register block
//
// Notes on behaviour
// [RULE1] byte, halfword, word accesses, each atomic
// [RULE2] every byte lane individually writable and readable
// [RULE3] zero written to clear bit: no change
// [RULE4] one written to clear bit unprotects
// [RULE5] read 1 means protected, 0 unprotected
// [RULE6] clear register offset zero, reset value fixed
// [RULE7] fixed peripheral bit map, bits 1 to 19
// [RULE8] timer and serial bits behave the same
// [RULE9] set register sets bit, both views equal
// [RULE10] write to protected peripheral refused with error
// [RULE11] setting already protected bit gives error
// [RULE12] debugger writes bypass the protection
// [RULE13] unassigned bits ignore writes, read reset value
`ifndef PWG_PARAMS_SVH
`define PWG_PARAMS_SVH

// ----------------------------------------------------------------
// bus and register map
// ----------------------------------------------------------------
`define PWG_ADDR_W        12
`define PWG_OFF_B_CLEAR   12'h000
`define PWG_OFF_B_SET     12'h004
`define PWG_OFF_A_CLEAR   12'h008
`define PWG_OFF_A_SET     12'h00c

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PWG_B_RESET       32'h0080_0000
`define PWG_A_RESET       32'h0000_0000

// ----------------------------------------------------------------
// bit map, second bridge
// ----------------------------------------------------------------
`define PWG_BIT_TOUCH     19
`define PWG_BIT_DAC       18
`define PWG_BIT_COMP      17
`define PWG_BIT_ADC       16
`define PWG_BIT_TIMER_LO  8
`define PWG_NUM_TIMERS    8
`define PWG_BIT_SERIAL_LO 2
`define PWG_NUM_SERIAL    6
`define PWG_BIT_EVENT     1

// ----------------------------------------------------------------
// bit map, first bridge
// ----------------------------------------------------------------
`define PWG_BIT_CLKGEN    3
`define PWG_BIT_SYSCTL    2
`define PWG_BIT_PWRMGR    1

`endif

//--- pwg_pkg.sv
// types shared by the peripheral write guard modules
package pwg_pkg;

   typedef logic [31:0] pwg_word_t;
   typedef logic [3:0]  pwg_strb_t;
   typedef logic [4:0]  pwg_index_t;

   typedef enum logic [2:0] {
      PWG_REG_NONE,
      PWG_REG_B_CLEAR,
      PWG_REG_B_SET,
      PWG_REG_A_CLEAR,
      PWG_REG_A_SET
   } pwg_reg_e;

endpackage

//--- pwg_lane_mask.sv
// expands byte strobes into a bit mask
`timescale 1ns/1ps
`default_nettype none

module pwg_lane_mask
   import pwg_pkg::*;
(
   input  wire pwg_strb_t strb,
   output pwg_word_t      mask
);

   // each lane stands alone so byte and halfword writes touch only their bits
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         mask[i*8 +: 8] = {8{strb[i]}}; // [RULE2]
      end
   end

endmodule

`default_nettype wire

//--- pwg_access_check.sv
// judges one peripheral write against its protect bit
`timescale 1ns/1ps
`default_nettype none

module pwg_access_check
   import pwg_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       req_valid,
   input  wire logic       req_write,
   input  wire logic       req_debug,
   input  wire pwg_index_t req_index,
   input  wire pwg_word_t  guard_vec,
   output logic            done_q,
   output logic            allow_q,
   output logic            error_q
);

   logic done_d;
   logic allow_d;
   logic error_d;
   logic blocked;

   always_comb
   begin
      // debugger traffic never meets the guard
      blocked = req_write && guard_vec[req_index] && !req_debug; // [RULE10] [RULE12]
      done_d  = req_valid;
      allow_d = req_valid && !blocked;
      error_d = req_valid && blocked; // [RULE10]
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_q  <= 1'b0;
         allow_q <= 1'b0;
         error_q <= 1'b0;
      end
      else
      begin
         done_q  <= done_d;
         allow_q <= allow_d;
         error_q <= error_d;
      end
   end

endmodule

`default_nettype wire

//--- pwg_top.sv
// peripheral write guard: protect registers on apb and access check
//
// The implementer's own choice: register access over APB.
`include "pwg_params.svh"
`timescale 1ns/1ps
`default_nettype none

module pwg_top
   import pwg_pkg::*;
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`PWG_ADDR_W-1:0] paddr,
   input  wire pwg_word_t              pwdata,
   input  wire pwg_strb_t              pstrb,
   output pwg_word_t                   prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   chk_valid,
   input  wire logic                   chk_write,
   input  wire logic                   chk_debug,
   input  wire logic                   chk_bank_b,
   input  wire pwg_index_t             chk_index,
   output logic                        chk_done,
   output logic                        chk_allow,
   output logic                        chk_error,
   output pwg_word_t                   guard_a,
   output pwg_word_t                   guard_b
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   function automatic pwg_word_t valid_b();
      pwg_word_t m;
      m = '0;
      m[`PWG_BIT_TOUCH] = 1'b1;
      m[`PWG_BIT_DAC]   = 1'b1;
      m[`PWG_BIT_COMP]  = 1'b1;
      m[`PWG_BIT_ADC]   = 1'b1;
      for (int i = 0; i < `PWG_NUM_TIMERS; i++)
      begin
         m[`PWG_BIT_TIMER_LO + i] = 1'b1; // [RULE8]
      end
      for (int i = 0; i < `PWG_NUM_SERIAL; i++)
      begin
         m[`PWG_BIT_SERIAL_LO + i] = 1'b1; // [RULE8]
      end
      m[`PWG_BIT_EVENT] = 1'b1;
      return m; // [RULE7]
   endfunction

   function automatic pwg_word_t valid_a();
      pwg_word_t m;
      m = '0;
      m[`PWG_BIT_CLKGEN] = 1'b1;
      m[`PWG_BIT_SYSCTL] = 1'b1;
      m[`PWG_BIT_PWRMGR] = 1'b1;
      return m;
   endfunction

   function automatic pwg_reg_e decode(input logic [`PWG_ADDR_W-1:0] a);
      pwg_reg_e r;
      if (a == `PWG_OFF_B_CLEAR)
      begin
         r = PWG_REG_B_CLEAR; // [RULE6]
      end
      else if (a == `PWG_OFF_B_SET)
      begin
         r = PWG_REG_B_SET;
      end
      else if (a == `PWG_OFF_A_CLEAR)
      begin
         r = PWG_REG_A_CLEAR;
      end
      else if (a == `PWG_OFF_A_SET)
      begin
         r = PWG_REG_A_SET;
      end
      else
      begin
         r = PWG_REG_NONE;
      end
      return r;
   endfunction

   // only ones in enabled lanes at assigned bits act; zeros never do
   function automatic pwg_word_t apply(input pwg_word_t cur,
                                       input pwg_word_t wdata,
                                       input pwg_word_t lanes,
                                       input pwg_word_t valid,
                                       input logic      set_op);
      pwg_word_t hit;
      hit = wdata & lanes & valid; // [RULE3] [RULE13]
      if (set_op)
      begin
         return cur | hit; // [RULE9]
      end
      return cur & ~hit; // [RULE4]
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------

   localparam pwg_word_t VALID_B = valid_b();
   localparam pwg_word_t VALID_A = valid_a();

   pwg_word_t lane_bits;
   pwg_reg_e  sel_reg;
   logic      setup;
   logic      commit;

   pwg_word_t guard_a_q;
   pwg_word_t guard_a_d;
   pwg_word_t guard_b_q;
   pwg_word_t guard_b_d;

   logic      pready_q;
   logic      pready_d;
   logic      pslverr_q;
   logic      pslverr_d;
   pwg_word_t prdata_q;
   pwg_word_t prdata_d;

   pwg_word_t chk_vec;

   // ----------------------------------------------------------------
   // lane decode
   // ----------------------------------------------------------------

   pwg_lane_mask u_lane
   (
      .strb (pstrb),
      .mask (lane_bits)
   );

   // ----------------------------------------------------------------
   // protect state
   // ----------------------------------------------------------------

   assign sel_reg = decode(paddr);
   assign setup   = psel && !penable;
   // the write lands only on the edge that also closes the transfer
   assign commit  = psel && penable && pready_q && pwrite;

   always_comb
   begin
      guard_a_d = guard_a_q;
      guard_b_d = guard_b_q;
      if (commit)
      begin
         // whole write in one edge, so no partial update is ever visible
         case (sel_reg)
            PWG_REG_B_CLEAR:
            begin
               guard_b_d = apply(guard_b_q, pwdata, lane_bits, VALID_B, 1'b0); // [RULE1] [RULE4]
            end
            PWG_REG_B_SET:
            begin
               guard_b_d = apply(guard_b_q, pwdata, lane_bits, VALID_B, 1'b1); // [RULE9]
            end
            PWG_REG_A_CLEAR:
            begin
               guard_a_d = apply(guard_a_q, pwdata, lane_bits, VALID_A, 1'b0);
            end
            PWG_REG_A_SET:
            begin
               guard_a_d = apply(guard_a_q, pwdata, lane_bits, VALID_A, 1'b1);
            end
            default:
            begin
               guard_a_d = guard_a_q;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         guard_a_q <= `PWG_A_RESET;
         guard_b_q <= `PWG_B_RESET; // [RULE6]
      end
      else
      begin
         guard_a_q <= guard_a_d;
         guard_b_q <= guard_b_d;
      end
   end

   // ----------------------------------------------------------------
   // apb response
   // ----------------------------------------------------------------

   // one wait-free access phase: answer prepared during setup
   always_comb
   begin
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      prdata_d  = '0;
      if (setup)
      begin
         pready_d = 1'b1;
         case (sel_reg)
            PWG_REG_B_CLEAR,
            PWG_REG_B_SET:
            begin
               // both views show one stored vector
               prdata_d = pwrite ? '0 : guard_b_q; // [RULE5] [RULE9] [RULE13]
               if (pwrite && sel_reg == PWG_REG_B_SET)
               begin
                  pslverr_d = |(pwdata & lane_bits & VALID_B & guard_b_q); // [RULE11]
               end
            end
            PWG_REG_A_CLEAR,
            PWG_REG_A_SET:
            begin
               prdata_d = pwrite ? '0 : guard_a_q; // [RULE5]
               if (pwrite && sel_reg == PWG_REG_A_SET)
               begin
                  pslverr_d = |(pwdata & lane_bits & VALID_A & guard_a_q); // [RULE11]
               end
            end
            default:
            begin
               pslverr_d = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end
      else
      begin
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign prdata  = prdata_q;
   assign guard_a = guard_a_q;
   assign guard_b = guard_b_q;

   // ----------------------------------------------------------------
   // peripheral access check
   // ----------------------------------------------------------------

   // judged on the vector as it stands, before any write in this cycle
   assign chk_vec = chk_bank_b ? guard_b_q : guard_a_q;

   pwg_access_check u_check
   (
      .clk       (pclk),
      .rst_n     (presetn),
      .req_valid (chk_valid),
      .req_write (chk_write),
      .req_debug (chk_debug),
      .req_index (chk_index),
      .guard_vec (chk_vec),
      .done_q    (chk_done),
      .allow_q   (chk_allow),
      .error_q   (chk_error) // [RULE10] [RULE12]
   );

endmodule

`default_nettype wire

//--- pwg_top_props.sv
// checker for the write guard register block ports
`include "pwg_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pwg_top_props
   import pwg_pkg::*;
(
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [`PWG_ADDR_W-1:0] paddr,
   input wire pwg_word_t              pwdata,
   input wire pwg_strb_t              pstrb,
   input wire pwg_word_t              prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic                   chk_valid,
   input wire logic                   chk_write,
   input wire logic                   chk_debug,
   input wire logic                   chk_bank_b,
   input wire pwg_index_t             chk_index,
   input wire logic                   chk_done,
   input wire logic                   chk_allow,
   input wire logic                   chk_error,
   input wire pwg_word_t              guard_b
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // only assigned bits count, spare bits must never move
   pwg_word_t wm;
   logic      wr_bc;
   logic      wr_bs;
   assign wm = pwdata & {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}} & 32'h000f_fffe;
   assign wr_bc = psel && penable && pready && pwrite && paddr == `PWG_OFF_B_CLEAR;
   assign wr_bs = psel && penable && pready && pwrite && paddr == `PWG_OFF_B_SET;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   a_answer_next: assert property (s_setup |=> pready ##1 !pready)
      else $error("ready not one cycle after setup");
   a_read_view: assert property (s_setup and !pwrite && paddr == `PWG_OFF_B_CLEAR |=> prdata == guard_b)
      else $error("clear view read differs from vector");
   a_zero_keeps: assert property (wr_bc |=> ((guard_b ^ $past(guard_b)) & ~$past(wm)) == 32'h0)
      else $error("zero or masked bit changed");
   a_one_clears: assert property (wr_bc |=> (guard_b & $past(wm)) == 32'h0)
      else $error("one written did not unprotect");
   a_set_sets: assert property (wr_bs |=> (guard_b & $past(wm)) == $past(wm))
      else $error("set write did not protect");
   a_double_set: assert property (s_setup and pwrite && paddr == `PWG_OFF_B_SET && (guard_b & wm) != 0
      |=> pslverr)
      else $error("double protection not flagged");
   a_spare_fixed: assert property (guard_b[31:20] == 12'h008 && !guard_b[0])
      else $error("spare bits moved");
   a_block_err: assert property (chk_valid && chk_write && !chk_debug && chk_bank_b && guard_b[chk_index]
      |=> chk_done && chk_error && !chk_allow)
      else $error("protected write not refused");
   a_debug_pass: assert property (chk_valid && chk_debug |=> chk_done && chk_allow && !chk_error)
      else $error("debugger access refused");
endmodule
bind pwg_top pwg_top_props chk_u (.*);
`default_nettype wire

//--- pwg_periph_model.sv
// processor side model issuing peripheral accesses to be judged
`timescale 1ns/1ps
`default_nettype none
module pwg_periph_model
   import pwg_pkg::*;
(
   input  wire logic pclk,
   input  wire logic chk_done,
   input  wire logic chk_allow,
   output var logic  chk_valid,
   output var logic  chk_write,
   output var logic  chk_debug,
   output var logic  chk_bank_b,
   output pwg_index_t chk_index
);
   int commits = 0;
   initial
   begin
      chk_valid = 1'b0;
      chk_write = 1'b0;
      chk_debug = 1'b0;
      chk_bank_b = 1'b0;
      chk_index = '0;
   end
   // peripheral register only takes accesses that were let through, reads as well as writes
   always @(posedge pclk)
      if (chk_done && chk_allow) commits++;
   task automatic access(input logic w, input logic dbg, input logic b, input pwg_index_t i);
      @(posedge pclk);
      chk_valid <= 1'b1;
      chk_write <= w;
      chk_debug <= dbg;
      chk_bank_b <= b;
      chk_index <= i;
      @(posedge pclk);
      // write and index fields show junk, not the last request; debug and bank fields keep it
      chk_valid <= 1'b0;
      chk_write <= ~w;
      chk_index <= ~i;
   endtask
endmodule
`default_nettype wire

//--- peripheral_write_protect_clear_test.sv
// self-checking bench for the write guard register block
`timescale 1ns/1ps
`default_nettype none
module peripheral_write_protect_clear_test
   import pwg_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   pwg_word_t   pwdata = 32'h0;
   pwg_strb_t   pstrb = 4'h0;
   pwg_word_t   prdata, guard_a, guard_b, r;
   logic        pready, pslverr, chk_valid, chk_write, chk_debug, chk_bank_b, chk_done, chk_allow, chk_error;
   pwg_index_t  chk_index;
   pwg_word_t   gb = 32'h0080_0000;
   pwg_word_t   ga = 32'h0;
   int          err_count = 0;
   int          checked = 0;
   int          cyc = 0;
   int          allowed = 0;
   logic [32:0] exp_q[$];
   logic [32:0] chk_q[$];
   pwg_top dut_u (.*);
   pwg_periph_model model_u (.*);
   always #25 pclk = ~pclk;
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   function automatic pwg_word_t lfsr(input pwg_word_t x);
      return {1'b0, x[31:1]} ^ (x[0] ? 32'h8020_0003 : 32'h0);
   endfunction
   task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] s);
      checked++;
      if (e !== s)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input pwg_word_t d, input pwg_strb_t s);
      pwg_word_t m, mk, cur, v;
      logic      e;
      m = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      e = !(a inside {12'h000, 12'h004, 12'h008, 12'h00c});
      v = 32'h0;
      if (!e)
      begin
         mk = a[3] ? 32'h0000_000e : 32'h000f_fffe;
         cur = a[3] ? ga : gb;
         if (!w) v = cur;
         else if (a[2]) e = |(cur & m & mk);
         if (w) cur = a[2] ? cur | (m & mk) : cur & ~(m & mk);
         if (a[3]) ga = cur;
         else gb = cur;
      end
      exp_q.push_back({e, v});
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // no assumed latency: waits for pready, bounded only by the bench timeout
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
   task automatic peek(input logic w, input logic dbg, input logic b, input pwg_index_t i);
      logic e;
      e = w && !dbg && (b ? gb[i] : ga[i]);
      chk_q.push_back({31'h0, !e, e});
      if (!e) allowed++;
      model_u.access(w, dbg, b, i);
   endtask
   // ----------------------------------------------------------------
   // result watcher and timeout
   // ----------------------------------------------------------------
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1) cmp("apb", exp_q.pop_front(), {pslverr, prdata});
      if (chk_done === 1'b1) cmp("check", chk_q.pop_front(), {31'h0, chk_allow, chk_error});
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         conclude();
      end
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial
   begin
      r = 32'hd6f4;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int k = 0; k < 16; k += 4) xfer(0, k[11:0], 32'h0, 4'hf);
      xfer(1, 12'h004, 32'hffff_ffff, 4'hf);
      xfer(1, 12'h00c, 32'hffff_ffff, 4'hf);
      for (int i = 0; i < 20; i++)
      begin
         peek(1, 0, 1, i[4:0]);
         peek(1, 1, 1, i[4:0]);
         peek(1, 0, 0, i[4:0]);
         xfer(1, 12'h000, 32'h1 << i, 4'hf);
         xfer(1, 12'h008, 32'h1 << i, 4'hf);
         peek(1, 0, 1, i[4:0]);
         xfer(1, 12'h004, 32'h1 << i, 4'hf);
         xfer(1, 12'h004, 32'h1 << i, 4'hf);
      end
      for (int k = 0; k < 24; k++)
      begin
         r = lfsr(r);
         xfer(1, {8'h00, r[9:8], 2'b00}, r, r[13:10]);
         xfer(0, {8'h00, r[9], 3'b000}, 32'h0, 4'hf);
         xfer(0, {8'h00, r[9], 3'b100}, 32'h0, 4'hf);
         peek(r[14], r[15], r[16], {1'b0, r[20:17]});
      end
      xfer(1, 12'h010, 32'hffff_ffff, 4'hf);
      xfer(0, 12'h006, 32'h0, 4'hf);
      xfer(0, 12'h000, 32'h0, 4'hf);
      repeat (4) @(posedge pclk);
      cmp("pending", 33'h0, 33'(exp_q.size() + chk_q.size()));
      cmp("guard_b", {1'b0, gb}, {1'b0, guard_b});
      cmp("guard_a", {1'b0, ga}, {1'b0, guard_a});
      cmp("commits", 33'(allowed), 33'(model_u.commits));
      conclude();
   end
endmodule
`default_nettype wire
